// *** core/uie_pkg.sv ***
// How it works
// [R1] Writing one to the CTS bit of the set register turns its enable on.
// [R2] Writing one to the deasserted bit of the set register enables that interrupt.
// [R3] Writing one to the byte received bit enables it; it reads back one.
// [R4] Writing one to the byte sent bit enables it; it reads back one.
// [R5] Writing one to the error bit enables it; it reads back one.
// [R6] Writing one to the receiver timeout bit enables it; it reads back one.
// [R7] Writing one to the clear register disables; both registers read the same enables.
// [R8] After reset all six enables are zero.
// [R9] The deasserted event fires when the synchronised CTS input rises.
// [R10] The byte received event fires when a received byte becomes available.
// [R11] Written zeros change nothing; the interrupt stands while an enabled flag is set.
package uie_pkg;

    localparam int unsigned NUM_EVT      = 6;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned OFS_W        = 12;

    localparam logic [11:0] OFS_INTEN_SET = 12'h304;
    localparam logic [11:0] OFS_INTEN_CLR = 12'h308;
    localparam logic [11:0] OFS_EVENTS    = 12'h310;

    localparam int unsigned BIT_CTS       = 0;
    localparam int unsigned BIT_CTS_OFF   = 1;
    localparam int unsigned BIT_RXRDY     = 2;
    localparam int unsigned BIT_TXSENT    = 3;
    localparam int unsigned BIT_ERROR     = 4;
    localparam int unsigned BIT_TIMEOUT   = 5;

    localparam logic [5:0]  EN_RESET      = 6'h00;
    localparam logic [5:0]  FLAGS_RESET   = 6'h00;
    localparam logic [1:0]  SETTLE_DONE   = 2'h3;
    localparam logic [1:0]  SETTLE_STEP   = 2'h1;
    localparam logic        HRESP_OKAY    = 1'h0;
    localparam logic        HREADY_ALWAYS = 1'h1;

endpackage

// *** core/uie_evt_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface uie_evt_if #(
    parameter int unsigned N = uie_pkg::NUM_EVT
);
    logic [N-1:0] flags;
    logic [N-1:0] clear;

    modport capture (output flags, input clear);
    modport ctrl    (input flags, output clear);
endinterface
`default_nettype wire

// *** core/uie_event_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
module uie_event_capture #(
    parameter int unsigned N = uie_pkg::NUM_EVT
) (
    // Clock and reset.
    input  wire logic      clk,
    input  wire logic      reset,
    // Event sources.
    input  wire logic      cts_pin,
    input  wire logic      rx_byte_ready,
    input  wire logic      tx_byte_sent,
    input  wire logic      error_seen,
    input  wire logic      rx_timeout,
    // Flags towards the register block.
    uie_evt_if.capture     evt
);

    typedef struct packed {
        logic         cts_meta;
        logic         cts_sync;
        logic         cts_prev;
        logic [1:0]   settle;
        logic [N-1:0] flags;
    } uie_cap_state_t;

    uie_cap_state_t s;
    uie_cap_state_t next_s;
    logic [N-1:0]   raw;
    logic           settled;

    // Edges are ignored until the synchroniser has filled, so a pin held high through reset is not an event.
    assign settled = (s.settle == uie_pkg::SETTLE_DONE);

    always_comb begin
        next_s = s;
        raw = '0;
        next_s.cts_meta = cts_pin;
        next_s.cts_sync = s.cts_meta;
        next_s.cts_prev = s.cts_sync;
        if (!settled) begin
            next_s.settle = s.settle + uie_pkg::SETTLE_STEP;
        end
        raw[uie_pkg::BIT_CTS]     = settled & s.cts_prev & ~s.cts_sync;
        raw[uie_pkg::BIT_CTS_OFF] = settled & ~s.cts_prev & s.cts_sync; // R9
        raw[uie_pkg::BIT_RXRDY]   = rx_byte_ready; // R10
        raw[uie_pkg::BIT_TXSENT]  = tx_byte_sent;
        raw[uie_pkg::BIT_ERROR]   = error_seen;
        raw[uie_pkg::BIT_TIMEOUT] = rx_timeout;
        // A new event in the cycle of its clear wins.
        next_s.flags = (s.flags & ~evt.clear) | raw;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign evt.flags = s.flags;

    a_deassert_rise: assert property (@(posedge clk) disable iff (reset) // R9
        (settled && !s.cts_prev && s.cts_sync) |=> s.flags[uie_pkg::BIT_CTS_OFF])
        else $error("CTS rise did not raise the deasserted flag");

    a_rx_ready: assert property (@(posedge clk) disable iff (reset) // R10
        rx_byte_ready |=> s.flags[uie_pkg::BIT_RXRDY])
        else $error("Received byte did not raise its flag");

    a_event_wins: assert property (@(posedge clk) disable iff (reset) // R10
        (|raw) |=> ((s.flags & $past(raw)) == $past(raw)))
        else $error("An event was lost against its clear");

endmodule
`default_nettype wire

// *** core/uie_intenable.sv ***
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uie_intenable #(
    parameter int unsigned N = uie_pkg::NUM_EVT
) (
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        RESET,
    // AHB-Lite slave.
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Serial engine events.
    input  wire logic        CTS,
    input  wire logic        RX_BYTE_READY,
    input  wire logic        TX_BYTE_SENT,
    input  wire logic        ERROR_DETECTED,
    input  wire logic        RX_TIMEOUT,
    // Interrupt request.
    output logic             IRQ
);

    typedef struct packed {
        logic [N-1:0]                   en;
        logic                           wr_pend;
        logic [uie_pkg::OFS_W-1:0]      wr_ofs;
        logic [uie_pkg::DATA_W-1:0]     rdata;
        logic                           irq;
    } uie_reg_state_t;

    uie_reg_state_t s;
    uie_reg_state_t next_s;
    logic           accept;
    logic [N-1:0]   wdat;
    logic [N-1:0]   clr;

    uie_evt_if #(.N(N)) evt ();

    uie_event_capture #(.N(N)) u_capture (
        .clk           (CLK),
        .reset         (RESET),
        .cts_pin       (CTS),
        .rx_byte_ready (RX_BYTE_READY),
        .tx_byte_sent  (TX_BYTE_SENT),
        .error_seen    (ERROR_DETECTED),
        .rx_timeout    (RX_TIMEOUT),
        .evt           (evt.capture)
    );

    // Only whole-word transfers are expected, so HSIZE is not decoded.
    assign accept = HSEL & HTRANS[1] & HREADY;
    assign wdat   = HWDATA[N-1:0];

    always_comb begin
        next_s = s;
        clr = '0;
        if (s.wr_pend) begin
            case (s.wr_ofs)
                uie_pkg::OFS_INTEN_SET: begin
                    next_s.en = s.en | wdat; // R1 R2 R3 R4 R5 R6 R11
                end
                uie_pkg::OFS_INTEN_CLR: begin
                    next_s.en = s.en & ~wdat; // R7 R11
                end
                uie_pkg::OFS_EVENTS: begin
                    clr = wdat;
                end
                default: begin
                end
            endcase
        end
        next_s.wr_pend = accept & HWRITE;
        next_s.wr_ofs  = HADDR[uie_pkg::OFS_W-1:0];
        // Read data is taken from the next-state values, so a read right behind a write sees its effect.
        if (accept && !HWRITE) begin
            case (HADDR[uie_pkg::OFS_W-1:0])
                uie_pkg::OFS_INTEN_SET, uie_pkg::OFS_INTEN_CLR: begin
                    next_s.rdata = {{(uie_pkg::DATA_W-N){1'b0}}, next_s.en}; // R7
                end
                uie_pkg::OFS_EVENTS: begin
                    next_s.rdata = {{(uie_pkg::DATA_W-N){1'b0}}, evt.flags & ~clr};
                end
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end
        next_s.irq = |(evt.flags & s.en); // R11
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            s <= '0;
            s.en <= uie_pkg::EN_RESET; // R8
        end else begin
            s <= next_s;
        end
    end

    assign evt.clear = clr;
    assign HRDATA    = s.rdata;
    assign HREADYOUT = uie_pkg::HREADY_ALWAYS;
    assign HRESP     = uie_pkg::HRESP_OKAY;
    assign IRQ       = s.irq;

    a_cts_set: assert property (@(posedge CLK) disable iff (RESET) // R1
        (s.wr_pend && s.wr_ofs == uie_pkg::OFS_INTEN_SET && HWDATA[uie_pkg::BIT_CTS])
        |=> s.en[uie_pkg::BIT_CTS])
        else $error("CTS enable not set");

    a_deassert_set: assert property (@(posedge CLK) disable iff (RESET) // R2
        (s.wr_pend && s.wr_ofs == uie_pkg::OFS_INTEN_SET && HWDATA[uie_pkg::BIT_CTS_OFF])
        |=> s.en[uie_pkg::BIT_CTS_OFF])
        else $error("Deasserted enable not set");

    a_rxrdy_readback: assert property (@(posedge CLK) disable iff (RESET) // R3
        (accept && !HWRITE && HADDR[uie_pkg::OFS_W-1:0] == uie_pkg::OFS_INTEN_SET
         && (s.en[uie_pkg::BIT_RXRDY]
             || (s.wr_pend && s.wr_ofs == uie_pkg::OFS_INTEN_SET && wdat[uie_pkg::BIT_RXRDY]))
         && !(s.wr_pend && s.wr_ofs == uie_pkg::OFS_INTEN_CLR && wdat[uie_pkg::BIT_RXRDY]))
        |=> HRDATA[uie_pkg::BIT_RXRDY])
        else $error("Byte received enable did not read back");

    a_txsent_set: assert property (@(posedge CLK) disable iff (RESET) // R4
        (s.wr_pend && s.wr_ofs == uie_pkg::OFS_INTEN_SET && HWDATA[uie_pkg::BIT_TXSENT])
        |=> s.en[uie_pkg::BIT_TXSENT])
        else $error("Byte sent enable not set");

    a_error_set: assert property (@(posedge CLK) disable iff (RESET) // R5
        (s.wr_pend && s.wr_ofs == uie_pkg::OFS_INTEN_SET && HWDATA[uie_pkg::BIT_ERROR])
        |=> s.en[uie_pkg::BIT_ERROR])
        else $error("Error enable not set");

    a_timeout_set: assert property (@(posedge CLK) disable iff (RESET) // R6
        (s.wr_pend && s.wr_ofs == uie_pkg::OFS_INTEN_SET && HWDATA[uie_pkg::BIT_TIMEOUT])
        |=> s.en[uie_pkg::BIT_TIMEOUT])
        else $error("Receiver timeout enable not set");

    a_clear_bits: assert property (@(posedge CLK) disable iff (RESET) // R7
        (s.wr_pend && s.wr_ofs == uie_pkg::OFS_INTEN_CLR)
        |=> (s.en & $past(wdat)) == '0)
        else $error("Clear register left an enable on");

    a_reset_zero: assert property (@(posedge CLK) // R8
        RESET |=> (s.en == uie_pkg::EN_RESET && !IRQ))
        else $error("Enables not zero after reset");

    a_zero_keeps: assert property (@(posedge CLK) disable iff (RESET) // R11
        (s.wr_pend && wdat == '0) |=> $stable(s.en))
        else $error("Writing zero changed an enable");

    a_irq_level: assert property (@(posedge CLK) disable iff (RESET) // R11
        (|(evt.flags & s.en)) |=> IRQ)
        else $error("Interrupt missing while an enabled flag is set");

    a_irq_falls: assert property (@(posedge CLK) disable iff (RESET) // R11
        !(|(evt.flags & s.en)) |=> !IRQ)
        else $error("Interrupt stands with no enabled flag");

    a_set_only_adds: assert property (@(posedge CLK) disable iff (RESET) // R11
        (s.wr_pend && s.wr_ofs == uie_pkg::OFS_INTEN_SET)
        |=> ((s.en & $past(s.en)) == $past(s.en)))
        else $error("Set register turned an enable off");

    a_clear_only_removes: assert property (@(posedge CLK) disable iff (RESET) // R11
        (s.wr_pend && s.wr_ofs == uie_pkg::OFS_INTEN_CLR)
        |=> ((s.en & ~$past(s.en)) == '0))
        else $error("Clear register turned an enable on");

    a_other_keeps_en: assert property (@(posedge CLK) disable iff (RESET) // R11
        (!s.wr_pend || (s.wr_ofs != uie_pkg::OFS_INTEN_SET && s.wr_ofs != uie_pkg::OFS_INTEN_CLR))
        |=> $stable(s.en))
        else $error("Enables changed without a set or clear write");

    a_read_enables: assert property (@(posedge CLK) disable iff (RESET) // R7
        (accept && !HWRITE && !s.wr_pend
         && (HADDR[uie_pkg::OFS_W-1:0] == uie_pkg::OFS_INTEN_SET
             || HADDR[uie_pkg::OFS_W-1:0] == uie_pkg::OFS_INTEN_CLR))
        |=> (HRDATA[N-1:0] == $past(s.en)))
        else $error("Enable register read returned the wrong state");

    a_read_unmapped: assert property (@(posedge CLK) disable iff (RESET) // R7
        (accept && !HWRITE
         && HADDR[uie_pkg::OFS_W-1:0] != uie_pkg::OFS_INTEN_SET
         && HADDR[uie_pkg::OFS_W-1:0] != uie_pkg::OFS_INTEN_CLR
         && HADDR[uie_pkg::OFS_W-1:0] != uie_pkg::OFS_EVENTS)
        |=> (HRDATA == '0))
        else $error("Unmapped read returned nonzero data");

    // Software may sample read data late in the data phase, so it must hold until the next read.
    a_rdata_holds: assert property (@(posedge CLK) disable iff (RESET) // R7
        !(accept && !HWRITE) |=> $stable(HRDATA))
        else $error("Read data changed without a read");

    a_upper_zero: assert property (@(posedge CLK) disable iff (RESET) // R7
        HRDATA[uie_pkg::DATA_W-1:N] == '0)
        else $error("Unused read data bits are not zero");

    a_reset_flags: assert property (@(posedge CLK) // R8
        RESET |=> (evt.flags == uie_pkg::FLAGS_RESET))
        else $error("Event flags not zero after reset");

endmodule
`default_nettype wire

// *** dv/uie_testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Clock, reset and bus.
    logic        CLK     = 1'b0;
    logic        RESET   = 1'b1;
    logic        HSEL    = 1'b0;
    logic [31:0] HADDR   = 32'h0;
    logic [1:0]  HTRANS  = 2'h0;
    logic        HWRITE  = 1'b0;
    logic [2:0]  HSIZE   = 3'h0;
    logic [31:0] HWDATA  = 32'h0;
    logic [31:0] HRDATA;
    logic        HREADYOUT;
    logic        HRESP;
    // Events and interrupt.
    logic        CTS     = 1'b0;
    logic [3:0]  ev      = 4'h0;
    logic        IRQ;
    int          bad_count  = 0;
    int          num_checks = 0;
    logic [31:0] rd;
    logic [31:0] exp;

    always #5 CLK = ~CLK;

    // The single slave closes its own ready loop, as on a one-slave bus.
    uie_intenable DUT (
        .CLK            (CLK),
        .RESET          (RESET),
        .HSEL           (HSEL),
        .HADDR          (HADDR),
        .HTRANS         (HTRANS),
        .HWRITE         (HWRITE),
        .HSIZE          (HSIZE),
        .HWDATA         (HWDATA),
        .HREADY         (HREADYOUT),
        .HRDATA         (HRDATA),
        .HREADYOUT      (HREADYOUT),
        .HRESP          (HRESP),
        .CTS            (CTS),
        .RX_BYTE_READY  (ev[0]),
        .TX_BYTE_SENT   (ev[1]),
        .ERROR_DETECTED (ev[2]),
        .RX_TIMEOUT     (ev[3]),
        .IRQ            (IRQ)
    );

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // Single word transfer; each phase waits for ready under a bounded count.
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge CLK);
        HSEL   <= 1'b1;
        HADDR  <= {20'h0, a};
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HSIZE  <= 3'h2;
        do begin @(posedge CLK); n++; end while (HREADYOUT !== 1'b1 && n < 100);
        HTRANS <= 2'h0;
        HWDATA <= wr ? wd : 32'h0;
        do begin @(posedge CLK); n++; end while (HREADYOUT !== 1'b1 && n < 100);
        rd = HRDATA;
        HSEL <= 1'b0;
        if (n >= 100) begin
            bad_count++;
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] want);
        ahb(1'b0, a, 32'h0);
        chk(rd, want);
    endtask

    task automatic pulse(input int i);
        @(posedge CLK);
        ev[i-2] <= 1'b1;
        @(posedge CLK);
        ev <= 4'h0;
    endtask

    initial begin
        repeat (3) @(posedge CLK);
        RESET <= 1'b0;
        rdchk(12'h304, 32'h0);
        rdchk(12'h308, 32'h0);
        chk({31'h0, IRQ}, 32'h0);
        chk({30'h0, HREADYOUT, HRESP}, 32'h2);
        $display("test reset values done");
        exp = 32'h0;
        for (int i = 0; i < 6; i++) begin
            ahb(1'b1, 12'h304, 32'h1 << i);
            exp = exp | (32'h1 << i);
            rdchk(12'h304, exp);
            rdchk(12'h308, exp);
        end
        ahb(1'b1, 12'h304, 32'h0);
        ahb(1'b1, 12'h308, 32'h0);
        rdchk(12'h304, 32'h3f);
        rdchk(12'h30c, 32'h0);
        for (int i = 0; i < 6; i++) begin
            ahb(1'b1, 12'h308, 32'h1 << i);
            exp = exp & ~(32'h1 << i);
            rdchk(12'h308, exp);
            rdchk(12'h304, exp);
        end
        $display("test set and clear done");
        for (int i = 2; i < 6; i++) begin
            ahb(1'b1, 12'h304, 32'h1 << i);
            pulse(i);
            @(posedge CLK);
            #1 chk({31'h0, IRQ}, 32'h1);
            rdchk(12'h310, 32'h1 << i);
            ahb(1'b1, 12'h310, 32'h1 << i);
            @(posedge CLK);
            #1 chk({31'h0, IRQ}, 32'h0);
            ahb(1'b1, 12'h308, 32'h1 << i);
            pulse(i);
            repeat (2) @(posedge CLK);
            #1 chk({31'h0, IRQ}, 32'h0);
            ahb(1'b1, 12'h310, 32'h1 << i);
        end
        $display("test event interrupts done");
        ahb(1'b1, 12'h304, 32'h2);
        CTS <= 1'b1;
        repeat (6) @(posedge CLK);
        rdchk(12'h310, 32'h2);
        chk({31'h0, IRQ}, 32'h1);
        CTS <= 1'b0;
        repeat (6) @(posedge CLK);
        rdchk(12'h310, 32'h3);
        ahb(1'b1, 12'h310, 32'h3);
        ahb(1'b1, 12'h308, 32'h3);
        repeat (2) @(posedge CLK);
        chk({31'h0, IRQ}, 32'h0);
        $display("test clear to send done");
        finish_test();
    end

    // The sequence needs well under a thousand cycles; this cuts a hang short.
    initial begin
        repeat (3000) @(posedge CLK);
        bad_count++;
        finish_test();
    end
endmodule
`default_nettype wire
